//--- rtl/pbrf_regs.v
// Base configuration and status register bank of a two-port cable PHY, APB slave
// Operation
// [RULE1] Hold six-bit node identifier, signal when valid
// [RULE2] Root flag cleared by bus reset, set if root
// [RULE3] Cable power bit follows sense input level
// [RULE4] Become-root request survives bus reset, hardware-cleared
// [RULE5] Long reset request waits for traffic end
// [RULE6] Long reset request cleared by any reset
// [RULE7] Gap value written by software or config packet
// [RULE8] Gap reloads 3Fh after two unwritten bus resets
// [RULE9] Extended set marker reads 111b
// [RULE10] Port quantity reads two, read-only
// [RULE11] Max rate code reads 010b
// [RULE12] Repeat latency code reads zero
// [RULE13] Self-ID link bit is override AND power status
// [RULE14] Link override set by hardware reset only
// [RULE15] Link interface state follows power status only
// [RULE16] Contender bit strapped from pin, to self-ID
// [RULE17] Repeat variation code reads zero
// [RULE18] Energy class strapped from pins, writable, to self-ID
// [RULE19] Base registers fixed at indices 0h to 7h
// [RULE20] Reserved registers and bits read zero
// [RULE21] Writes to read-only fields are ignored
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`include "pbrf_map.vh"
`timescale 1ns/1ps
`default_nettype none

module pbrf_regs #(
	parameter integer LONG_RESET_CYCLES = `PBRF_LONG_RESET_NS / `PBRF_CLK_PERIOD_NS
) (
	input  wire        pclk,                 // System clock, 100 MHz
	input  wire        presetn,              // Hardware reset, async, active low
	input  wire        psel,                 // APB select
	input  wire        penable,              // APB access phase
	input  wire        pwrite,               // APB direction, high for write
	input  wire [11:0] paddr,                // APB byte address
	input  wire [31:0] pwdata,               // APB write data
	input  wire [3:0]  pstrb,                // APB byte strobes
	output reg  [31:0] prdata,               // APB read data
	output reg         pready,               // APB ready
	output reg         pslverr,              // APB error, unmapped address
	input  wire        bus_reset_pulse,      // Bus reset seen by arbiter
	input  wire        self_id_done_pulse,   // Self-identification finished
	input  wire [5:0]  self_id_node_value,   // Identifier found by self-ID
	input  wire        tree_root_pulse,      // Tree-ID made this node root
	input  wire        config_gap_pulse,     // Config packet sent or received
	input  wire [5:0]  config_gap_value,     // Gap carried by config packet
	input  wire        link_traffic_busy,    // Receive or transmit in progress
	input  wire        cable_power_sense,    // Cable power pin
	input  wire        link_power_status,    // Link power status pin
	input  wire        contender_or_link_on, // Contender strap pin
	input  wire [2:0]  energy_class_pins,    // Energy class strap pins
	output reg         node_id_valid,        // Identifier valid since self-ID
	output reg         status_reg0_request,  // Unsolicited register 0 transfer
	output reg         root_attempt,         // Try to become root next reset
	output reg         long_reset_start,     // Start of long bus reset, pulse
	output reg         long_reset_active,    // Long bus reset in progress
	output reg  [5:0]  gap_value_out,        // Gap for arbitration timers
	output reg         self_id_link_bit,     // Self-ID bit 9
	output reg         self_id_contender,    // Self-ID bit 20
	output reg  [2:0]  self_id_energy_class, // Self-ID bits 21 to 23
	output reg         link_if_enable        // Link interface operational
);

	// All-zero byte for reserved words and write cycles
	localparam [7:0] ZB = `PBRF_ZERO_BYTE;

	// Word index of an APB address, 0 to 7
	function [2:0] pbrf_index;
		input [11:0] addr;
		begin
			pbrf_index = addr[`PBRF_IDX_MSB:`PBRF_IDX_LSB];
		end
	endfunction

	// An address is mapped when it falls in the eight base words
	function pbrf_mapped;
		input [11:0] addr;
		begin
			pbrf_mapped = (addr[`PBRF_ADDR_W-1:`PBRF_HIGH_LSB] == 7'h00);
		end
	endfunction

	// Synchroniser stages for the pins
	reg        cps_s1_reg;               // Cable power, first stage
	reg        cps_s2_reg;               // Cable power, second stage
	reg        lps_s1_reg;               // Link power, first stage
	reg        lps_s2_reg;               // Link power, second stage
	reg        con_s1_reg;               // Contender, first stage
	reg        con_s2_reg;               // Contender, second stage
	reg  [2:0] nec_s1_reg;               // Energy class, first stage
	reg  [2:0] nec_s2_reg;               // Energy class, second stage

	// Register fields
	reg  [5:0] node_identifier_reg;      // Node identifier
	reg        top_node_flag_reg;        // Root flag
	reg        become_top_request_reg;   // Root holdoff request
	reg        long_reset_request_reg;   // Long bus reset request
	reg  [5:0] arbitration_gap_reg;      // Gap count
	reg        link_active_override_reg; // Link active control
	reg        manager_hopeful_reg;      // Contender bit
	reg  [2:0] node_energy_class_reg;    // Power class

	// Bookkeeping
	reg  [1:0] strap_cnt_reg;            // Cycles since reset release
	reg        gap_written_reg;          // Gap written since last bus reset
	reg        reset_seen_reg;           // One bus reset already counted
	reg [31:0] long_cnt_reg;             // Long reset duration counter

	// Access decode
	wire       access_w;                 // Access phase cycle
	wire       commit_w;                 // Edge at which the master sees ready
	wire       wr_w;                     // Committed write to a mapped word
	wire [2:0] idx_w;                    // Word index
	wire       wr_ctrl_w;                // Write hits register 1
	wire       wr_link_w;                // Write hits register 4
	wire       strap_load_w;             // Strap capture cycle
	wire       lr_go_w;                  // Long reset may start now
	reg  [7:0] rd_byte;                  // Read mux output

	assign access_w  = psel & penable;
	assign commit_w  = access_w & pready;
	assign idx_w     = pbrf_index(paddr);
	assign wr_w      = commit_w & pwrite & pbrf_mapped(paddr) & pstrb[0];
	// Only registers 1 and 4 hold writable bits; other writes are dropped
	assign wr_ctrl_w = wr_w & (idx_w == `PBRF_IDX_CTRL); // [RULE21]
	assign wr_link_w = wr_w & (idx_w == `PBRF_IDX_LINK); // [RULE21]
	assign strap_load_w = (strap_cnt_reg == `PBRF_STRAP_WAIT);
	// A request raised during traffic waits for the traffic to end
	assign lr_go_w = long_reset_request_reg & ~link_traffic_busy & ~long_reset_active
		& ~bus_reset_pulse; // [RULE5]

	// Two-flop synchronisers; the first stage feeds only the second
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cps_s1_reg <= 1'b0;
			cps_s2_reg <= 1'b0;
			lps_s1_reg <= 1'b0;
			lps_s2_reg <= 1'b0;
			con_s1_reg <= 1'b0;
			con_s2_reg <= 1'b0;
			nec_s1_reg <= 3'h0;
			nec_s2_reg <= 3'h0;
		end else begin
			cps_s1_reg <= cable_power_sense;
			cps_s2_reg <= cps_s1_reg;
			lps_s1_reg <= link_power_status;
			lps_s2_reg <= lps_s1_reg;
			con_s1_reg <= contender_or_link_on;
			con_s2_reg <= con_s1_reg;
			nec_s1_reg <= energy_class_pins;
			nec_s2_reg <= nec_s1_reg;
		end
	end

	// Counts the cycles the synchronisers need after reset release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt_reg <= 2'h0;
		end else if (strap_cnt_reg != `PBRF_STRAP_SAT) begin
			strap_cnt_reg <= strap_cnt_reg + 2'h1;
		end
	end

	// APB handshake: one wait state so read data comes from a flip-flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `PBRF_ZERO_WORD;
		end else if (access_w & ~pready) begin
			pready  <= 1'b1;
			pslverr <= ~pbrf_mapped(paddr);
			// Data beyond the low byte reads zero
			prdata  <= {`PBRF_ZERO_HI, (pwrite ? ZB : rd_byte)}; // [RULE20]
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `PBRF_ZERO_WORD;
		end
	end

	// Read mux; bit 0 of the printed layout is the byte's MSB
	always @* begin
		rd_byte = ZB;
		if (pbrf_mapped(paddr)) begin
			case (idx_w) // [RULE19]
				`PBRF_IDX_NODE: begin
					rd_byte = {node_identifier_reg, top_node_flag_reg, cps_s2_reg}; // [RULE3]
				end
				`PBRF_IDX_CTRL: begin
					rd_byte = {become_top_request_reg, long_reset_request_reg, arbitration_gap_reg};
				end
				`PBRF_IDX_CAPA: begin
					rd_byte = {`PBRF_EXT_MARKER, `PBRF_PORT_QTY}; // [RULE9] [RULE10]
				end
				`PBRF_IDX_RATE: begin
					rd_byte = {`PBRF_MAX_RATE, `PBRF_RSVD_BIT, `PBRF_LATENCY}; // [RULE11] [RULE12]
				end
				`PBRF_IDX_LINK: begin
					rd_byte = {link_active_override_reg, manager_hopeful_reg,
						`PBRF_VARIATION, node_energy_class_reg}; // [RULE17]
				end
				default: begin
					// Interrupt, reserved and page words are not held here
					rd_byte = ZB; // [RULE20]
				end
			endcase
		end
	end

	// Node identifier and its validity; invalid from bus reset to self-ID end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_identifier_reg <= 6'h00;
			node_id_valid       <= 1'b0;
			status_reg0_request <= 1'b0;
		end else begin
			status_reg0_request <= self_id_done_pulse; // [RULE1]
			if (self_id_done_pulse) begin
				// Completion wins over a reset in the same cycle
				node_identifier_reg <= self_id_node_value; // [RULE1]
				node_id_valid       <= 1'b1;
			end else if (bus_reset_pulse) begin
				node_id_valid <= 1'b0; // [RULE1]
			end
		end
	end

	// Root flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_node_flag_reg <= 1'b0;
		end else if (tree_root_pulse) begin
			top_node_flag_reg <= 1'b1; // [RULE2]
		end else if (bus_reset_pulse) begin
			top_node_flag_reg <= 1'b0; // [RULE2]
		end
	end

	// Root request; bus reset leaves it alone
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			become_top_request_reg <= 1'b0;
			root_attempt           <= 1'b0;
		end else begin
			if (wr_ctrl_w) begin
				become_top_request_reg <= pwdata[`PBRF_BTR_BIT]; // [RULE4]
			end
			root_attempt <= wr_ctrl_w ? pwdata[`PBRF_BTR_BIT] : become_top_request_reg; // [RULE4]
		end
	end

	// Long bus reset request and its timed drive
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			long_reset_request_reg <= 1'b0;
			long_reset_start       <= 1'b0;
			long_reset_active      <= 1'b0;
			long_cnt_reg           <= 32'h0000_0000;
		end else begin
			long_reset_start <= lr_go_w; // [RULE5]
			if (lr_go_w) begin
				// Starting our own reset is itself a bus reset
				long_reset_request_reg <= 1'b0; // [RULE6]
			end else if (bus_reset_pulse) begin
				long_reset_request_reg <= 1'b0; // [RULE6]
			end else if (wr_ctrl_w) begin
				long_reset_request_reg <= pwdata[`PBRF_LRR_BIT];
			end
			if (lr_go_w) begin
				long_reset_active <= 1'b1;
				long_cnt_reg      <= LONG_RESET_CYCLES - 1; // [RULE5]
			end else if (long_reset_active) begin
				if (long_cnt_reg == 32'h0000_0000) begin
					long_reset_active <= 1'b0;
				end else begin
					long_cnt_reg <= long_cnt_reg - 32'h0000_0001;
				end
			end
		end
	end

	// Gap count; a write in the reset cycle counts as intervening
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arbitration_gap_reg <= `PBRF_GAP_RESET; // [RULE8]
			gap_written_reg     <= 1'b0;
			reset_seen_reg      <= 1'b0;
		end else begin
			if (wr_ctrl_w) begin
				arbitration_gap_reg <= pwdata[`PBRF_GAP_MSB:`PBRF_GAP_LSB]; // [RULE7]
			end else if (config_gap_pulse) begin
				arbitration_gap_reg <= config_gap_value; // [RULE7]
			end else if (bus_reset_pulse & reset_seen_reg & ~gap_written_reg) begin
				arbitration_gap_reg <= `PBRF_GAP_RESET; // [RULE8]
			end
			if (bus_reset_pulse) begin
				reset_seen_reg  <= 1'b1;
				gap_written_reg <= wr_ctrl_w | config_gap_pulse;
			end else if (wr_ctrl_w | config_gap_pulse) begin
				gap_written_reg <= 1'b1; // [RULE8]
			end
		end
	end

	// Link register: override, contender and energy class
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_active_override_reg <= 1'b1; // [RULE14]
			manager_hopeful_reg      <= 1'b0;
			node_energy_class_reg    <= 3'h0;
		end else if (strap_load_w) begin
			// Straps sampled once the synchronisers hold the pin levels
			manager_hopeful_reg   <= con_s2_reg; // [RULE16]
			node_energy_class_reg <= nec_s2_reg; // [RULE18]
		end else if (wr_link_w) begin
			link_active_override_reg <= pwdata[`PBRF_LAO_BIT];
			manager_hopeful_reg      <= pwdata[`PBRF_MHB_BIT];
			node_energy_class_reg    <= pwdata[`PBRF_NEC_MSB:`PBRF_NEC_LSB]; // [RULE18]
		end
	end

	// Self-ID fields and link interface state, registered outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			self_id_link_bit     <= 1'b0;
			self_id_contender    <= 1'b0;
			self_id_energy_class <= 3'h0;
			link_if_enable       <= 1'b0;
			gap_value_out        <= `PBRF_GAP_RESET;
		end else begin
			self_id_link_bit     <= link_active_override_reg & lps_s2_reg; // [RULE13]
			self_id_contender    <= manager_hopeful_reg; // [RULE16]
			self_id_energy_class <= node_energy_class_reg; // [RULE18]
			// The override never gates the interface itself
			link_if_enable       <= lps_s2_reg; // [RULE15]
			gap_value_out        <= arbitration_gap_reg; // [RULE7]
		end
	end

endmodule

`default_nettype wire

//--- common/pbrf_map.vh
// Register map, field layout and timing constants of the base register bank
`ifndef PBRF_MAP_VH
`define PBRF_MAP_VH

// Register indices as printed (byte address is four times the index)
`define PBRF_IDX_NODE        3'h0
`define PBRF_IDX_CTRL        3'h1
`define PBRF_IDX_CAPA        3'h2
`define PBRF_IDX_RATE        3'h3
`define PBRF_IDX_LINK        3'h4
`define PBRF_IDX_INTR        3'h5
`define PBRF_IDX_RSVD        3'h6
`define PBRF_IDX_PAGE        3'h7

// Address decode: word index bits and the high address bits that must be zero
`define PBRF_ADDR_W          12
`define PBRF_IDX_LSB         2
`define PBRF_IDX_MSB         4
`define PBRF_HIGH_LSB        5

// Field positions, register 0
`define PBRF_NODE_ID_MSB     7
`define PBRF_NODE_ID_LSB     2
`define PBRF_TOP_BIT         1
`define PBRF_CPOK_BIT        0
// Register 1
`define PBRF_BTR_BIT         7
`define PBRF_LRR_BIT         6
`define PBRF_GAP_MSB         5
`define PBRF_GAP_LSB         0
// Register 4
`define PBRF_LAO_BIT         7
`define PBRF_MHB_BIT         6
`define PBRF_NEC_MSB         2
`define PBRF_NEC_LSB         0

// Reset and fixed values
`define PBRF_GAP_RESET       6'h3F
`define PBRF_EXT_MARKER      3'h7
`define PBRF_PORT_QTY        5'h02
`define PBRF_MAX_RATE        3'h2
`define PBRF_LATENCY         4'h0
`define PBRF_VARIATION       3'h0
`define PBRF_RSVD_BIT        1'h0
`define PBRF_ZERO_BYTE       8'h00
`define PBRF_ZERO_WORD       32'h0000_0000
`define PBRF_ZERO_HI         24'h00_0000

// Timing
`define PBRF_CLK_PERIOD_NS   10
`define PBRF_LONG_RESET_NS   166000
`define PBRF_STRAP_WAIT      2'h2
`define PBRF_STRAP_SAT       2'h3

`endif

//--- sim/pbrf_checker.sv
// Port-level assertions for the base register bank
`timescale 1ns/1ps
`default_nettype none
module pbrf_checker #(
	parameter integer LONG_RESET_CYCLES = 16600
) (
	input wire logic        pclk,                // Clock
	input wire logic        presetn,             // Async reset, low
	input wire logic        psel,                // APB select
	input wire logic        penable,             // APB access phase
	input wire logic        pwrite,              // APB direction
	input wire logic [11:0] paddr,               // APB address
	input wire logic [31:0] prdata,              // APB read data
	input wire logic        pready,              // APB ready
	input wire logic        pslverr,             // APB error
	input wire logic        bus_reset_pulse,     // Bus reset
	input wire logic        self_id_done_pulse,  // Self-ID done
	input wire logic        config_gap_pulse,    // Config packet
	input wire logic [5:0]  config_gap_value,    // Config gap
	input wire logic        link_traffic_busy,   // Traffic busy
	input wire logic        link_power_status,   // Link power pin
	input wire logic        node_id_valid,       // Identifier valid
	input wire logic        status_reg0_request, // Status transfer
	input wire logic        long_reset_start,    // Long reset start
	input wire logic        long_reset_active,   // Long reset on
	input wire logic [5:0]  gap_value_out,       // Gap in use
	input wire logic        self_id_link_bit,    // Self-ID link bit
	input wire logic        link_if_enable       // Link interface on
);
	logic [2:0]  up;      // Edges since reset, saturating
	logic [31:0] act_cnt; // Length of the current long reset

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Counters; the sync chain needs a few edges before its output is meaningful
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up <= 3'h0;
			act_cnt <= 32'h0;
		end else begin
			up <= (up == 3'h7) ? up : up + 3'h1;
			act_cnt <= long_reset_start ? 32'h1 : act_cnt + {31'h0, long_reset_active};
		end
	end

	AST_SID: assert property (self_id_done_pulse |=> node_id_valid && status_reg0_request)
		else $error("identifier not valid after self-id");
	AST_BRV: assert property (bus_reset_pulse && !self_id_done_pulse |=> !node_id_valid)
		else $error("identifier valid after bus reset");
	AST_CAPA: assert property (pready && !pwrite && paddr == 12'h008 |-> prdata == 32'h0000_00E2)
		else $error("capability word wrong");
	AST_RATE: assert property (pready && !pwrite && paddr == 12'h00C |-> prdata == 32'h0000_0040)
		else $error("rate word wrong");
	AST_RSVD: assert property (pready && !pwrite && paddr inside {12'h014, 12'h018, 12'h01C} |-> prdata == 32'h0)
		else $error("reserved word not zero");
	AST_HI: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	AST_ERR: assert property (pready |-> pslverr == (paddr >= 12'h020))
		else $error("error response wrong");
	AST_RDY: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("ready not a single pulse");
	AST_LIE: assert property (up > 3'h3 |-> link_if_enable == $past(link_power_status, 3))
		else $error("link enable not following power status");
	AST_LSB: assert property (self_id_link_bit |-> link_if_enable)
		else $error("link bit set with link inactive");
	AST_LRS: assert property ($rose(long_reset_active) |-> long_reset_start && !$past(link_traffic_busy))
		else $error("long reset started badly");
	AST_LRLEN: assert property ($fell(long_reset_active) |-> act_cnt == LONG_RESET_CYCLES)
		else $error("long reset length wrong");
	AST_GAP: assert property (config_gap_pulse && !bus_reset_pulse && !psel |=> ##1
		gap_value_out == $past(config_gap_value, 2))
		else $error("gap not taken from config packet");
endmodule
bind pbrf_regs pbrf_checker #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .bus_reset_pulse, .self_id_done_pulse, .config_gap_pulse,
	.config_gap_value, .link_traffic_busy, .link_power_status, .node_id_valid, .status_reg0_request,
	.long_reset_start, .long_reset_active, .gap_value_out, .self_id_link_bit, .link_if_enable);
`default_nettype wire

//--- sim/pbrf_bus_model.sv
// Bus protocol side: bus reset, tree-ID and self-ID sequence
`timescale 1ns/1ps
`default_nettype none
module pbrf_bus_model (
	input  wire logic       pclk,               // Clock
	input  wire logic       start,              // Begin a reset sequence
	input  wire logic       make_root,          // Win tree-ID
	input  wire logic [5:0] node,               // Identifier to hand out
	output var  logic       bus_reset_pulse,    // Bus reset
	output var  logic       tree_root_pulse,    // Became root
	output var  logic       self_id_done_pulse, // Self-ID complete
	output var  logic [5:0] self_id_node_value  // Identifier
);
	logic [2:0] st; // Sequence step, 0 is idle

	initial begin
		st = 3'h0;
		bus_reset_pulse = 1'b0;
		tree_root_pulse = 1'b0;
		self_id_done_pulse = 1'b0;
		self_id_node_value = 6'h2A;
	end

	// Steps: reset, gap, root, self-ID; identifier toggles when not qualified
	always @(posedge pclk) begin
		st <= (st == 3'h0) ? {2'h0, start} : ((st == 3'h4) ? 3'h0 : st + 3'h1);
		bus_reset_pulse <= (st == 3'h1);
		tree_root_pulse <= (st == 3'h3) && make_root;
		self_id_done_pulse <= (st == 3'h4);
		self_id_node_value <= (st == 3'h4) ? node : ~self_id_node_value;
	end
endmodule
`default_nettype wire

//--- sim/pbrf_regs_tb.sv
// Self-checking bench for the base register bank
`timescale 1ns/1ps
`default_nettype none
module pbrf_regs_tb;
	localparam integer LRC = 20; // Short long-reset for sim
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0] pstrb;
	logic bus_reset_pulse, self_id_done_pulse, tree_root_pulse, config_gap_pulse, link_traffic_busy;
	logic [5:0] self_id_node_value, config_gap_value, gap_value_out, node;
	logic cable_power_sense, link_power_status, contender_or_link_on, start, make_root, rerr;
	logic [2:0] energy_class_pins, self_id_energy_class;
	logic node_id_valid, status_reg0_request, root_attempt, long_reset_start, long_reset_active;
	logic self_id_link_bit, self_id_contender, link_if_enable;
	int errors, n_checks;
	logic [31:0] tab [8] = '{32'h01, 32'h3F, 32'hE2, 32'h40, 32'hC5, 32'h0, 32'h0, 32'h0};

	pbrf_regs #(.LONG_RESET_CYCLES(LRC)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .bus_reset_pulse, .self_id_done_pulse, .self_id_node_value,
		.tree_root_pulse, .config_gap_pulse, .config_gap_value, .link_traffic_busy, .cable_power_sense,
		.link_power_status, .contender_or_link_on, .energy_class_pins, .node_id_valid, .status_reg0_request,
		.root_attempt, .long_reset_start, .long_reset_active, .gap_value_out, .self_id_link_bit,
		.self_id_contender, .self_id_energy_class, .link_if_enable);
	pbrf_bus_model bm (.pclk, .start, .make_root, .node, .bus_reset_pulse, .tree_root_pulse,
		.self_id_done_pulse, .self_id_node_value);

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 1, pready);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), ex, rdat);
	endtask

	// Bus reset sequence through the model, waits for the status transfer
	task automatic brst(input logic r, input logic [5:0] id);
		int n;
		@(posedge pclk);
		make_root <= r;
		node <= id;
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (status_reg0_request !== 1'b1 && n < 20);
		chk("status request", 1, status_reg0_request);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Free-running clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Watchdog well beyond the expected run
	initial begin
		#100000;
		errors++;
		close_out();
	end

	initial begin
		{presetn, psel, penable, pwrite, start, make_root, config_gap_pulse, link_traffic_busy} = 8'h0;
		{paddr, pwdata, node, config_gap_value} = 56'h0;
		pstrb = 4'hF;
		{cable_power_sense, link_power_status, contender_or_link_on} = 3'h7;
		energy_class_pins = 3'h5;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		for (int i = 0; i < 8; i++) rd(i * 4, tab[i]);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) if (i != 1 && i != 4) apb(1'b1, i * 4, 32'hFF);
		for (int i = 0; i < 8; i++) rd(i * 4, tab[i]);
		rd(12'h020, 32'h0);
		chk("unmapped error", 1, rerr);
		apb(1'b1, 12'h004, 32'hFFFF_FF2A);
		rd(12'h004, 32'h2A);
		// A write without the low byte strobe must leave the gap alone
		pstrb <= 4'hE;
		apb(1'b1, 12'h004, 32'h15);
		pstrb <= 4'hF;
		rd(12'h004, 32'h2A);
		cable_power_sense <= 1'b0;
		repeat (5) @(posedge pclk);
		rd(12'h000, 32'h00);
		cable_power_sense <= 1'b1;
		$display("test access kinds done");
		apb(1'b1, 12'h004, 32'hAA);
		apb(1'b1, 12'h010, 32'h02);
		rd(12'h010, 32'h02);
		chk("root attempt", 1, root_attempt);
		chk("link bit off", 0, self_id_link_bit);
		chk("link enable", 1, link_if_enable);
		brst(1'b1, 6'h15);
		rd(12'h000, 32'h57);
		rd(12'h004, 32'hAA);
		rd(12'h010, 32'h02);
		brst(1'b0, 6'h09);
		rd(12'h000, 32'h25);
		rd(12'h004, 32'hBF);
		@(posedge pclk);
		config_gap_value <= 6'h11;
		config_gap_pulse <= 1'b1;
		@(posedge pclk);
		config_gap_pulse <= 1'b0;
		brst(1'b0, 6'h09);
		rd(12'h004, 32'h91);
		$display("test bus reset done");
		apb(1'b1, 12'h010, 32'h85);
		repeat (4) @(posedge pclk);
		chk("link bit on", 1, self_id_link_bit);
		chk("contender", 0, self_id_contender);
		chk("energy class", 5, self_id_energy_class);
		link_power_status <= 1'b0;
		repeat (5) @(posedge pclk);
		chk("link enable off", 0, link_if_enable);
		chk("link bit power off", 0, self_id_link_bit);
		link_power_status <= 1'b1;
		$display("test link control done");
		link_traffic_busy <= 1'b1;
		apb(1'b1, 12'h004, 32'hD1);
		rd(12'h004, 32'hD1);
		brst(1'b0, 6'h09);
		rd(12'h004, 32'h91);
		apb(1'b1, 12'h004, 32'hD1);
		repeat (6) @(posedge pclk);
		chk("held while busy", 0, long_reset_active);
		link_traffic_busy <= 1'b0;
		for (int n = 0; n < 20 && long_reset_start !== 1'b1; n++) @(posedge pclk);
		chk("long reset start", 1, long_reset_start);
		repeat (LRC + 4) @(posedge pclk);
		chk("long reset over", 0, long_reset_active);
		rd(12'h004, 32'h91);
		$display("test long reset done");
		// Hardware reset in mid-run must drop software settings and reload the straps
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("root attempt cleared", 0, root_attempt);
		for (int i = 0; i < 8; i++) rd(i * 4, tab[i]);
		$display("test hardware reset done");
		close_out();
	end
endmodule
`default_nettype wire
